// ==== common/hue_pkg.sv ====
// Purpose: constants and carriers for the host uart emulation registers
// Assumes: 8-bit host and local register ports, one clock
// Notes: local offsets are the low byte of the local address
package hue_pkg;

	// host offsets
	localparam logic [2:0] HOST_DATA = 3'h0;
	localparam logic [2:0] HOST_IER = 3'h1;
	localparam logic [2:0] HOST_LCR = 3'h3;
	localparam logic [2:0] HOST_LSR = 3'h5;
	localparam logic [2:0] HOST_MSR = 3'h6;
	localparam logic [2:0] HOST_SCR = 3'h7;

	// local offsets (low byte)
	localparam logic [7:0] LOC_RXDATA = 8'hf0;
	localparam logic [7:0] LOC_IER = 8'hf1;
	localparam logic [7:0] LOC_TXDATA = 8'hf2;
	localparam logic [7:0] LOC_LSR = 8'hf5;
	localparam logic [7:0] LOC_MSR = 8'hf6;
	localparam logic [7:0] LOC_SCR = 8'hf7;
	localparam logic [7:0] LOC_DLL = 8'hf8;
	localparam logic [7:0] LOC_DLM = 8'hf9;
	localparam logic [7:0] LOC_CTRL = 8'hfa;

	// field positions
	localparam int LCR_DIVSEL = 7;
	localparam int CTRL_RXTMR_EN = 0;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_NIB = 4'h0;

	// receive timer interval
	localparam int RX_TIMER_NS = 1000;
	localparam int CLK_NS = 10;
	localparam int RX_TIMER_CYC = (RX_TIMER_NS + CLK_NS - 1) / CLK_NS;
	localparam int FIFO_DEPTH = 4;

	// register bus request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hue_req_t;

endpackage

// ==== testbench/hue_loc_model.sv ====
// Purpose: local processor model answering the divisor interrupt
// Assumes: level interrupt in, one-cycle acknowledge out
// Notes: slow picks a late reaction, else the next cycle
`timescale 1ns/100ps
`default_nettype none
module hue_loc_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// interrupt handshake
	input wire logic slow,
	input wire logic locIrq,
	output logic locIrqAck
);
	logic [3:0] wait_q;
	always_ff @(posedge mclk) begin
		if (rst || !locIrq || locIrqAck) begin
			wait_q <= 4'h0;
			locIrqAck <= 1'b0;
		end else begin
			wait_q <= wait_q + 4'h1;
			locIrqAck <= wait_q == (slow ? 4'h6 : 4'h0);
		end
	end
endmodule
`default_nettype wire

// ==== testbench/hue_regs_chk.sv ====
// Purpose: port checks of the register file
// Assumes: one clock, synchronous reset
// Notes: divisor select and enables tracked from host writes
`timescale 1ns/100ps
`default_nettype none
module hue_regs_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// host side
	input wire hue_pkg::hue_req_t hostReq,
	input wire logic [7:0] hostRdata,
	input wire logic hostIrq,
	// local side
	input wire hue_pkg::hue_req_t locReq,
	input wire logic [7:0] locRdata,
	input wire logic locIrq,
	input wire logic locIrqAck,
	input wire logic rxReady
);
	logic sel_q;
	logic [3:0] ier_q;
	wire logic [2:0] ha = hostReq.addr[2:0];
	wire logic divWr = hostReq.wr && sel_q && ha[2:1] == 2'h0;
	wire logic lw = locReq.wr;
	wire logic msrRd = hostReq.rd && ha == 3'h6;
	wire logic lsrRd = hostReq.rd && ha == 3'h5;
	default clocking dcb @(posedge mclk);
	endclocking
	default disable iff (rst);
	always_ff @(posedge mclk) begin
		if (rst) begin
			sel_q <= 1'b0;
		end else if (hostReq.wr && ha == 3'h3) begin
			sel_q <= hostReq.wdata[7];
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			ier_q <= 4'h0;
		end else if (hostReq.wr && ha == 3'h1 && !sel_q) begin
			ier_q <= hostReq.wdata[3:0];
		end
	end
	AST_IER_HOST: assert property (
		hostReq.rd && ha == 3'h1 && !sel_q |=> hostRdata[7:4] == 4'h0)
		else $error("enable upper bits set");
	AST_IER_LOC: assert property (
		locReq.rd && locReq.addr == hue_pkg::LOC_IER
		|=> locRdata == {4'h0, $past(ier_q)}) else $error("local enable");
	AST_DIV_IRQ: assert property (
		divWr |=> locIrq) else $error("divisor write no irq");
	AST_ACK: assert property (
		locIrqAck && !divWr |=> !locIrq) else $error("ack ignored");
	AST_SCR: assert property (
		hostReq.wr && ha == 3'h7 && !locIrq |=> !locIrq)
		else $error("scratch write irq");
	AST_MASK: assert property (
		ier_q == 4'h0 |-> !hostIrq) else $error("masked host irq");
	AST_SHADOW: assert property (
		lw && locReq.addr == hue_pkg::LOC_RXDATA ##1 !hostReq.rd ##1
		locReq.rd && locReq.addr == hue_pkg::LOC_LSR |=> locRdata[0])
		else $error("shadow ready late");
	AST_MSR_CLR: assert property (
		(!lw)[*4] ##1 (msrRd && !lw) ##1 !lw ##1 msrRd
		|=> hostRdata[3:0] == 4'h0) else $error("deltas kept");
	AST_LSR_CLR: assert property (
		(!lw)[*4] ##1 (lsrRd && !lw) ##1 !lw ##1 lsrRd
		|=> hostRdata[4:1] == 4'h0) else $error("errors kept");
	cover property (divWr);
	cover property (lw && !rxReady);
	cover property (msrRd && hostIrq);
endmodule
bind hue_regs hue_regs_chk u_chk (.mclk(mclk), .rst(rst), .hostReq(hostReq),
	.hostRdata(hostRdata), .hostIrq(hostIrq), .locReq(locReq),
	.locRdata(locRdata), .locIrq(locIrq), .locIrqAck(locIrqAck),
	.rxReady(rxReady));
`default_nettype wire

// ==== testbench/hue_regs_tb.sv ====
// Purpose: bench for the host uart emulation registers
// Assumes: receive timer shortened to 20 cycles
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none
module hue_regs_tb;
	localparam int TMR = 20;
	localparam logic H = 1'b1;
	localparam logic L = 1'b0;
	localparam logic W = 1'b1;
	localparam logic RD = 1'b0;
	localparam logic [7:0] Z = 8'h00;
	logic mclk, rst, hostIrq, locIrq, ack, rxReady, slow;
	logic [7:0] hRd, lRd, r;
	hue_pkg::hue_req_t hRq, lRq;
	int n_fail, n_compared;
	hue_regs #(.RX_TIMER(TMR)) u_dut (.mclk(mclk), .rst(rst),
		.hostReq(hRq), .hostRdata(hRd), .hostIrq(hostIrq), .locReq(lRq),
		.locRdata(lRd), .locIrq(locIrq), .locIrqAck(ack),
		.rxReady(rxReady));
	hue_loc_model u_loc (.mclk(mclk), .rst(rst), .slow(slow),
		.locIrq(locIrq), .locIrqAck(ack));
	task automatic ck(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one access, result left in r
	task automatic x(input logic h, input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge mclk);
		#1;
		if (h)
			hRq = '{!w, w, a, d};
		else
			lRq = '{!w, w, a, d};
		@(posedge mclk);
		#1;
		hRq = '0;
		lRq = '0;
		r = h ? hRd : lRd;
	endtask
	task automatic give_verdict();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic t_regs();
		x(H, RD, 8'h01, Z);
		ck(r, 8'h00);
		x(H, W, 8'h01, 8'hff);
		x(H, RD, 8'h01, Z);
		ck(r, 8'h0f);
		x(L, W, 8'hf1, Z);
		x(L, RD, 8'hf1, Z);
		ck(r, 8'h0f);
		x(H, W, 8'h01, Z);
		x(H, W, 8'h07, 8'ha5);
		ck(8'(locIrq), 8'h00);
		x(L, RD, 8'hf7, Z);
		ck(r, 8'ha5);
		x(H, RD, 8'h04, Z);
		ck(r, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_div();
		x(H, W, 8'h03, 8'h80);
		x(H, W, 8'h00, 8'h34);
		ck(8'(locIrq), 8'h01);
		slow = 1'b1;
		x(H, W, 8'h01, 8'h12);
		ck(8'(locIrq), 8'h01);
		x(H, RD, 8'h00, Z);
		ck(r, 8'h34);
		x(L, RD, 8'hf8, Z);
		ck(r, 8'h34);
		x(L, RD, 8'hf9, Z);
		ck(r, 8'h12);
		for (int i = 0; i < 20 && locIrq !== 1'b0; i++) begin
			#10;
		end
		ck(8'(locIrq), 8'h00);
		if (locIrq !== 1'b0)
			give_verdict();
		slow = 1'b0;
		x(H, W, 8'h03, Z);
		x(H, RD, 8'h01, Z);
		ck(r, 8'h00);
		$display("test divisor done");
	endtask
	task automatic t_rx();
		x(H, W, 8'h01, 8'h01);
		x(L, W, 8'hf0, 8'h5a);
		ck(8'(hostIrq), 8'h01);
		x(H, RD, 8'h05, Z);
		ck(r & 8'h01, 8'h01);
		x(H, RD, 8'h00, Z);
		ck(r, 8'h5a);
		ck(8'(hostIrq), 8'h00);
		x(L, RD, 8'hf5, Z);
		ck(r & 8'h01, 8'h00);
		ck(8'(hostIrq), 8'h00);
		x(H, W, 8'h01, 8'h04);
		x(L, W, 8'hf5, 8'h04);
		for (int i = 0; i < 4; i++) begin
			x(L, W, 8'hf0, 8'h10 + 8'(i));
		end
		ck(8'(rxReady), 8'h00);
		x(L, W, 8'hf0, 8'hee);
		ck(8'(hostIrq), 8'h01);
		repeat (4) @(posedge mclk);
		x(H, RD, 8'h05, Z);
		ck(r & 8'h1e, 8'h06);
		x(H, RD, 8'h05, Z);
		ck(r & 8'h1e, 8'h00);
		ck(8'(hostIrq), 8'h00);
		for (int i = 0; i < 4; i++) begin
			x(H, RD, 8'h00, Z);
			ck(r, 8'h10 + 8'(i));
		end
		ck(8'(rxReady), 8'h01);
		x(H, W, 8'h01, Z);
		$display("test receive done");
	endtask
	task automatic t_tmr();
		x(L, W, 8'hfa, 8'h01);
		x(L, W, 8'hf0, 8'h77);
		x(L, W, 8'hf0, 8'h78);
		x(L, RD, 8'hf5, Z);
		ck(r & 8'h01, 8'h01);
		x(H, RD, 8'h05, Z);
		ck(r & 8'h01, 8'h00);
		repeat (TMR) @(posedge mclk);
		x(H, RD, 8'h05, Z);
		ck(r & 8'h01, 8'h01);
		x(H, RD, 8'h00, Z);
		ck(r, 8'h77);
		x(H, RD, 8'h05, Z);
		ck(r & 8'h01, 8'h01);
		x(H, RD, 8'h00, Z);
		ck(r, 8'h78);
		x(H, RD, 8'h05, Z);
		ck(r & 8'h01, 8'h00);
		x(L, W, 8'hfa, Z);
		$display("test timer done");
	endtask
	task automatic t_msr();
		x(H, W, 8'h01, 8'h08);
		x(L, W, 8'hf6, 8'hf0);
		ck(8'(hostIrq), 8'h01);
		repeat (4) @(posedge mclk);
		x(H, RD, 8'h06, Z);
		ck(r, 8'hfb);
		x(H, RD, 8'h06, Z);
		ck(r, 8'hf0);
		ck(8'(hostIrq), 8'h00);
		x(L, W, 8'hf6, Z);
		x(H, RD, 8'h06, Z);
		ck(r, 8'h0f);
		x(H, W, 8'h01, 8'h02);
		x(H, W, 8'h00, 8'h3c);
		ck(8'(hostIrq), 8'h00);
		x(L, RD, 8'hf2, Z);
		ck(r, 8'h3c);
		ck(8'(hostIrq), 8'h01);
		$display("test modem done");
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		give_verdict();
	end
	initial begin
		rst = 1'b1;
		hRq = '0;
		lRq = '0;
		slow = 1'b0;
		repeat (10) @(posedge mclk);
		#1;
		rst = 1'b0;
		t_regs();
		t_div();
		t_rx();
		t_tmr();
		t_msr();
		give_verdict();
	end
endmodule
`default_nettype wire

// ==== verilog/hue_fifo.sv ====
// Purpose: small receive queue
// Assumes: single clock, synchronous reset
// Notes: full and empty are exact
`timescale 1ns/100ps
`default_nettype none
module hue_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign inReady = (count_q != DEPTH[AW:0]);
	assign outValid = (count_q != '0);
	assign outData = mem[rdPtr_q];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verilog/hue_regs.sv ====
// Purpose: host uart emulation register file
// Assumes: host and local ports are single-cycle strobes on mclk
// Notes: local side writes modem inputs, rx bytes and error shadows
//
// Contract
// - data-ready sets at once without timer
// - timer delays host data-ready; shadow immediate
// - both flags clear when queue emptied
// - enable bits 7..4 read zero
// - modem deltas with enable bit 3 interrupt
// - line errors with enable bit 2 interrupt
// - holding-empty with enable bit 1 interrupt
// - data-ready or timeout with bit 0 interrupt
// - carrier change sets delta bit 3
// - ring falling edge sets bit 2
// - dsr/cts change sets bits 1/0
// - host modem-status read clears deltas
// - enable reg host rw, local read
// - scratch host rw, local read, no irq
// - low divisor at 00 when selected
// - high divisor at 01 when selected
// - host divisor write interrupts local processor
// - host line-status read clears errors
`timescale 1ns/100ps
`default_nettype none
module hue_regs #(
	parameter int RX_TIMER = hue_pkg::RX_TIMER_CYC,
	parameter int DEPTH = hue_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// host register port
	input wire hue_pkg::hue_req_t hostReq,
	output logic [7:0] hostRdata,
	output logic hostIrq,
	// local processor register port
	input wire hue_pkg::hue_req_t locReq,
	output logic [7:0] locRdata,
	output logic locIrq,
	input wire logic locIrqAck,
	// receive queue fill status
	output logic rxReady
);
	logic [7:0] ier_q;
	logic [7:0] scr_q;
	logic [7:0] dll_q;
	logic [7:0] dlm_q;
	logic [7:0] lcr_q;
	logic [7:0] txHold_q;
	logic transmit_holding_empty_q;
	logic [3:0] msrIn_q;
	logic [3:0] msrDelta_q;
	logic [3:0] errShadow_q;
	logic [3:0] err_q;
	logic [7:0] ctrl_q;
	logic drHost_q;
	logic [15:0] rxTmr_q;
	logic rxTimeout_q;
	logic locIrq_q;
	logic [7:0] hostRdata_q;
	logic [7:0] locRdata_q;
	logic divSel;
	logic hostRd;
	logic hostWr;
	logic locRd;
	logic locWr;
	logic rxPush;
	logic rxPop;
	logic rxValid;
	logic [7:0] rxData;
	logic rxEmptyNext;
	logic [3:0] msrNew;
	logic [3:0] deltaSet;
	logic [2:0] h;
	logic [7:0] l;
	localparam int CW = $clog2(DEPTH) + 1;
	logic [CW-1:0] rxCount_q;
	logic rxAccept;
	logic rxTmrEn;
	logic rxTmrDone;

	assign h = hostReq.addr[2:0];
	assign l = locReq.addr;
	assign hostRd = hostReq.rd;
	assign hostWr = hostReq.wr;
	assign locRd = locReq.rd;
	assign locWr = locReq.wr;
	assign divSel = lcr_q[hue_pkg::LCR_DIVSEL];

	////////////////////////////////////////////////////////////////////
	// receive queue
	assign rxPush = locWr && (l == hue_pkg::LOC_RXDATA);
	assign rxPop = hostRd && !divSel && (h == hue_pkg::HOST_DATA) && rxValid;

	hue_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rxQueue (
		.mclk(mclk),
		.rst(rst),
		.inValid(rxPush),
		.inReady(rxReady),
		.inData(locReq.wdata),
		.outValid(rxValid),
		.outReady(rxPop),
		.outData(rxData)
	);
	assign rxAccept = rxPush && rxReady;
	// last byte leaving and none arriving
	assign rxEmptyNext = rxPop && !rxAccept && (rxCount_q == CW'(1));
	assign rxTmrEn = ctrl_q[hue_pkg::CTRL_RXTMR_EN];
	assign rxTmrDone = (rxTmr_q == 16'h0001);

	// occupancy kept beside the queue
	always_ff @(posedge mclk) begin
		if (rst) begin
			rxCount_q <= '0;
		end else if (rxAccept && !rxPop) begin
			rxCount_q <= rxCount_q + 1'b1;
		end else if (rxPop && !rxAccept) begin
			rxCount_q <= rxCount_q - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// data-ready with receive timer
	always_ff @(posedge mclk) begin
		if (rst || !rxTmrEn) begin
			rxTmr_q <= '0;
		end else if (rxPush) begin
			rxTmr_q <= 16'(RX_TIMER);
		end else if (rxTmr_q != '0) begin
			rxTmr_q <= rxTmr_q - 16'h0001;
		end
	end

	// host-visible flag
	always_ff @(posedge mclk) begin
		if (rst) begin
			drHost_q <= 1'b0;
		end else if (!rxTmrEn) begin
			drHost_q <= rxPush || (rxValid && !rxEmptyNext);
		end else if (rxEmptyNext) begin
			drHost_q <= 1'b0;
		end else if (rxTmrDone && !rxPush) begin
			drHost_q <= rxValid;
		end
	end

	// timeout: interval ran out with data
	always_ff @(posedge mclk) begin
		if (rst || !rxTmrEn || rxPush) begin
			rxTimeout_q <= 1'b0;
		end else if (rxTmrDone) begin
			rxTimeout_q <= rxValid && !rxEmptyNext;
		end else if (rxPop) begin
			rxTimeout_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// host writable registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			ier_q <= hue_pkg::RST_BYTE;
			scr_q <= hue_pkg::RST_BYTE;
			dll_q <= hue_pkg::RST_BYTE;
			dlm_q <= hue_pkg::RST_BYTE;
			lcr_q <= hue_pkg::RST_BYTE;
		end else if (hostWr) begin
			unique case (h)
				hue_pkg::HOST_DATA: begin
					if (divSel) begin
						dll_q <= hostReq.wdata;
					end
				end
				hue_pkg::HOST_IER: begin
					if (divSel) begin
						dlm_q <= hostReq.wdata;
					end else begin
						ier_q <= {4'h0, hostReq.wdata[3:0]};
					end
				end
				hue_pkg::HOST_LCR: lcr_q <= hostReq.wdata;
				hue_pkg::HOST_SCR: scr_q <= hostReq.wdata;
				default: ;
			endcase
		end
	end

	// transmit holding byte from host
	always_ff @(posedge mclk) begin
		if (rst) begin
			txHold_q <= hue_pkg::RST_BYTE;
			transmit_holding_empty_q <= 1'b1;
		end else if (hostWr && !divSel && h == hue_pkg::HOST_DATA) begin
			txHold_q <= hostReq.wdata;
			transmit_holding_empty_q <= 1'b0;
		end else if (locRd && l == hue_pkg::LOC_TXDATA) begin
			transmit_holding_empty_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// local processor interrupt and control
	always_ff @(posedge mclk) begin
		if (rst) begin
			locIrq_q <= 1'b0;
		end else if (hostWr && divSel &&
			(h == hue_pkg::HOST_DATA || h == hue_pkg::HOST_IER)) begin
			locIrq_q <= 1'b1;
		end else if (locIrqAck) begin
			locIrq_q <= 1'b0;
		end
	end
	assign locIrq = locIrq_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_q <= hue_pkg::RST_BYTE;
		end else if (locWr && l == hue_pkg::LOC_CTRL) begin
			ctrl_q <= locReq.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// modem status
	// local writes modem inputs
	assign msrNew = (locWr && l == hue_pkg::LOC_MSR) ?
		locReq.wdata[7:4] : msrIn_q;
	assign deltaSet[3] = msrNew[3] ^ msrIn_q[3];
	assign deltaSet[2] = msrIn_q[2] && !msrNew[2];
	assign deltaSet[1] = msrNew[1] ^ msrIn_q[1];
	assign deltaSet[0] = msrNew[0] ^ msrIn_q[0];

	always_ff @(posedge mclk) begin
		if (rst) begin
			msrIn_q <= hue_pkg::RST_NIB;
			msrDelta_q <= hue_pkg::RST_NIB;
		end else begin
			msrIn_q <= msrNew;
			if (hostRd && h == hue_pkg::HOST_MSR) begin
				msrDelta_q <= deltaSet;
			end else begin
				msrDelta_q <= msrDelta_q | deltaSet;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// line errors: shadow then host copy
	always_ff @(posedge mclk) begin
		if (rst) begin
			errShadow_q <= hue_pkg::RST_NIB;
		end else if (locWr && l == hue_pkg::LOC_LSR) begin
			errShadow_q <= {locReq.wdata[4:2], 1'b0};
		end else if (rxPush) begin
			errShadow_q <= hue_pkg::RST_NIB;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			err_q <= hue_pkg::RST_NIB;
		end else begin
			err_q <= ((hostRd && h == hue_pkg::HOST_LSR) ? 4'h0 : err_q) |
				(rxPush ? {errShadow_q[3:1], !rxReady} : 4'h0);
		end
	end

	////////////////////////////////////////////////////////////////////
	// host interrupt
	always_comb begin
		hostIrq = 1'b0;
		if (ier_q[3] && (msrDelta_q != 4'h0)) hostIrq = 1'b1;
		if (ier_q[2] && (err_q != 4'h0)) hostIrq = 1'b1;
		if (ier_q[1] && transmit_holding_empty_q) hostIrq = 1'b1;
		if (ier_q[0] && (drHost_q || rxTimeout_q)) hostIrq = 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// read data
	always_ff @(posedge mclk) begin
		if (rst) begin
			hostRdata_q <= hue_pkg::RST_BYTE;
		end else if (hostRd) begin
			unique case (h)
				hue_pkg::HOST_DATA: hostRdata_q <= divSel ? dll_q : rxData;
				hue_pkg::HOST_IER: hostRdata_q <= divSel ? dlm_q : ier_q;
				hue_pkg::HOST_LCR: hostRdata_q <= lcr_q;
				hue_pkg::HOST_LSR: hostRdata_q <=
					{1'b0, transmit_holding_empty_q, transmit_holding_empty_q, err_q[3:1], err_q[0], drHost_q};
				hue_pkg::HOST_MSR: hostRdata_q <= {msrIn_q, msrDelta_q};
				hue_pkg::HOST_SCR: hostRdata_q <= scr_q;
				default: hostRdata_q <= hue_pkg::RST_BYTE;
			endcase
		end
	end
	assign hostRdata = hostRdata_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			locRdata_q <= hue_pkg::RST_BYTE;
		end else if (locRd) begin
			unique case (l)
				hue_pkg::LOC_IER: locRdata_q <= ier_q;
				hue_pkg::LOC_TXDATA: locRdata_q <= txHold_q;
				hue_pkg::LOC_LSR: locRdata_q <=
					{1'b0, transmit_holding_empty_q, transmit_holding_empty_q, errShadow_q[3:1], !rxReady, rxValid};
				hue_pkg::LOC_MSR: locRdata_q <= {msrIn_q, msrDelta_q};
				hue_pkg::LOC_SCR: locRdata_q <= scr_q;
				hue_pkg::LOC_DLL: locRdata_q <= dll_q;
				hue_pkg::LOC_DLM: locRdata_q <= dlm_q;
				hue_pkg::LOC_CTRL: locRdata_q <= ctrl_q;
				default: locRdata_q <= hue_pkg::RST_BYTE;
			endcase
		end
	end
	assign locRdata = locRdata_q;
endmodule
`default_nettype wire
